// File: pkg/fpm_pkg.sv
// Constants, types and timing for the program-memory programming block.
// Assumes one 100 MHz core clock and pins sampled synchronously to it.
package fpm_pkg;

    // ****************************************************************
    // Geometry and frame layout
    // ****************************************************************
    localparam int WORD_W = 22;
    localparam int MEM_DEPTH = 8192;
    localparam int OP_W = 4;
    localparam int FRAME_W = OP_W + WORD_W;
    localparam int FIFO_DEPTH = 4;
    localparam int CRC_W = 16;
    localparam logic [WORD_W-1:0] ERASED_WORD = 22'h3F_FFFF;
    localparam logic [CRC_W-1:0] CRC_POLY = 16'h1021;
    localparam logic [CRC_W-1:0] CRC_INIT = 16'hFFFF;
    // Setup key value is arbitrary
    localparam logic [WORD_W-1:0] SETUP_KEY = 22'h2A_5C3B;

    // ****************************************************************
    // Commands carried in the frame opcode field
    // ****************************************************************
    localparam logic [OP_W-1:0] OP_ENTER = 4'h1;
    localparam logic [OP_W-1:0] OP_ERASE = 4'h2;
    localparam logic [OP_W-1:0] OP_WRITE = 4'h3;
    localparam logic [OP_W-1:0] OP_CRC = 4'h4;
    localparam logic [OP_W-1:0] OP_READ_LAST = 4'h5;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_KHZ = 100_000;
    localparam int ERASE_TIME_MS = 20;
    localparam int WRITE_TIME_US = 60;
    localparam int ERASE_CYCLES = ERASE_TIME_MS * CLK_KHZ;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_KHZ / 1000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READY = 3'b001,
        ST_ERASE = 3'b011,
        ST_WRITE = 3'b010,
        ST_CRC = 3'b110,
        ST_SEND = 3'b111
    } fpm_state_type;

    typedef struct packed {
        logic [OP_W-1:0] op;
        logic [WORD_W-1:0] data;
    } fpm_frame_type;

    typedef struct packed {
        logic force_en;
        logic [7:0] first_oe;
        logic [7:0] first_out;
        logic [4:0] low_bits_oe;
        logic six_oe;
        logic six_out;
    } fpm_pins_type;

endpackage : fpm_pkg

// File: hdl/fpm_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high clear.
`timescale 1ns/10ps
module fpm_fifo
    import fpm_pkg::*;
#(
    parameter int WIDTH = FRAME_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk, // Core clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic clear, // Flush contents
    input wire logic [WIDTH-1:0] in_data, // Write data
    input wire logic in_valid, // Write request
    output logic in_ready, // Room available
    output logic [WIDTH-1:0] out_data, // Head word
    output logic out_valid, // Head valid
    input wire logic out_ready // Head taken
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_reg;
    logic [PTR_W-1:0] rd_reg;
    logic [PTR_W:0] cnt_reg;
    logic push;
    logic pop;

    assign in_ready = (cnt_reg != (PTR_W+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end
        else if (clear)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_reg <= (wr_reg == PTR_W'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_reg <= (rd_reg == PTR_W'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

    chk_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_reg <= (PTR_W+1)'(DEPTH)) else $error("fifo count overflow");
endmodule : fpm_fifo

// File: hdl/fpm_serial.sv
// Serial frame receiver and word sender on the programming pins.
// Assumes serial clock and data inputs already synchronous to clk.
`timescale 1ns/10ps
module fpm_serial
    import fpm_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic active, // Programming terminal high
    input wire logic sclk_in, // Serial clock pin level
    input wire logic sdata_in, // Serial data pin level
    output logic sdata_out, // Serial data drive value
    output logic sdata_oe, // Serial data drive enable
    output fpm_frame_type frame, // Received frame
    output logic frame_valid, // Frame waiting
    input wire logic frame_ready, // Frame accepted
    input wire logic tx_load, // Start sending tx_word
    input wire logic [WORD_W-1:0] tx_word, // Word to send
    output logic tx_done // Pulse when last bit clocked out
);
    localparam int BIT_W = $clog2(FRAME_W + 1);

    logic sclk_prev_reg;
    logic rise;
    logic fall;
    logic [FRAME_W-1:0] rx_shift_reg;
    logic [BIT_W-1:0] rx_cnt_reg;
    logic [WORD_W-1:0] tx_shift_reg;
    logic [BIT_W-1:0] tx_cnt_reg;

    assign rise = sclk_in && !sclk_prev_reg;
    assign fall = !sclk_in && sclk_prev_reg;
    assign frame = fpm_frame_type'(rx_shift_reg);
    assign frame_valid = (rx_cnt_reg == BIT_W'(FRAME_W));
    assign sdata_out = tx_shift_reg[WORD_W-1];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            sclk_prev_reg <= sclk_in;
        end
    end

    // Receiver, MSB first; while a full frame waits, further bits are dropped until it is taken
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_shift_reg <= '0;
            rx_cnt_reg <= '0;
        end
        else if (!active)
        begin
            rx_cnt_reg <= '0;
        end
        else if (frame_valid)
        begin
            if (frame_ready)
            begin
                rx_cnt_reg <= '0;
            end
        end
        else if (rise && !sdata_oe)
        begin
            rx_shift_reg <= {rx_shift_reg[FRAME_W-2:0], sdata_in};
            rx_cnt_reg <= rx_cnt_reg + 1'b1;
        end
    end

    // Sender: first bit valid at load, next bit after each falling edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_shift_reg <= '0;
            tx_cnt_reg <= '0;
            sdata_oe <= 1'b0;
            tx_done <= 1'b0;
        end
        else
        begin
            tx_done <= 1'b0;
            if (!active)
            begin
                sdata_oe <= 1'b0;
            end
            else if (tx_load)
            begin
                tx_shift_reg <= tx_word;
                tx_cnt_reg <= '0;
                sdata_oe <= 1'b1;
            end
            else if (sdata_oe && fall)
            begin
                tx_shift_reg <= {tx_shift_reg[WORD_W-2:0], 1'b0};
                tx_cnt_reg <= tx_cnt_reg + 1'b1;
                if (tx_cnt_reg == BIT_W'(WORD_W - 1))
                begin
                    sdata_oe <= 1'b0;
                    tx_done <= 1'b1;
                end
            end
        end
    end

    chk_data_input_off: assert property (@(posedge clk) disable iff (!rst_n)
        !active |=> !sdata_oe) else $error("data pin driven while idle");
endmodule : fpm_serial

// File: hdl/fpm_prog_ctrl.sv
// Program-memory programming mode controller with on-chip flash array.
// Assumes the test terminal level is already a clean logic input.
`timescale 1ns/10ps
module fpm_prog_ctrl
    import fpm_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH,
    parameter int ERASE_CYC = ERASE_CYCLES,
    parameter int WRITE_CYC = WRITE_CYCLES
)
(
    input wire logic core_clk, // 100 MHz clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic prog_voltage_high, // Test terminal at program level
    input wire logic serial_clock_pin_in, // Serial clock pin level
    input wire logic serial_clock_pin_oe, // Always low while forced
    input wire logic serial_data_pin_in, // Serial data pin level
    output logic serial_data_pin_out, // Serial data drive value
    output logic serial_data_pin_oe, // Serial data drive enable
    output fpm_pins_type port_force, // Forced port setup
    output logic prog_mode, // Valid programming mode entered
    output logic cmd_refused // Last command was refused
);
    localparam int ADDR_W = $clog2(DEPTH);
    localparam int TMR_W = $clog2(ERASE_CYC + 1);

    // ****************************************************************
    // Reset release and memory
    // ****************************************************************
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [WORD_W-1:0] mem [DEPTH];

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_sync_reg <= 2'b00;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    function automatic logic [CRC_W-1:0] crc_step(
        input logic [CRC_W-1:0] crc,
        input logic [WORD_W-1:0] word
    );
        logic [CRC_W-1:0] c;
        c = crc;
        for (int i = WORD_W - 1; i >= 0; i--)
        begin
            c = (c[CRC_W-1] ^ word[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : crc_step

    // ****************************************************************
    // Serial link and command FIFO
    // ****************************************************************
    fpm_state_type state_reg;
    fpm_frame_type rx_frame;
    fpm_frame_type cmd;
    logic rx_valid;
    logic rx_ready;
    logic cmd_valid;
    logic cmd_pop;
    logic sdo;
    logic sdo_oe;
    logic tx_load_reg;
    logic tx_done;
    logic [WORD_W-1:0] tx_word_reg;

    fpm_serial u_serial (
        .clk(core_clk),
        .rst_n(rst_n),
        .active(prog_voltage_high),
        .sclk_in(serial_clock_pin_in),
        .sdata_in(serial_data_pin_in),
        .sdata_out(sdo),
        .sdata_oe(sdo_oe),
        .frame(rx_frame),
        .frame_valid(rx_valid),
        .frame_ready(rx_ready),
        .tx_load(tx_load_reg),
        .tx_word(tx_word_reg),
        .tx_done(tx_done)
    );

    // FIFO fills during long erase and write waits, stalling the receiver
    fpm_fifo #(.WIDTH(FRAME_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(core_clk),
        .rst_n(rst_n),
        .clear(!prog_voltage_high),
        .in_data(rx_frame),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .out_data(cmd),
        .out_valid(cmd_valid),
        .out_ready(cmd_pop)
    );

    assign cmd_pop = cmd_valid && (state_reg == ST_IDLE ||
        state_reg == ST_READY);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    logic [TMR_W-1:0] timer_reg;
    logic [ADDR_W:0] addr_reg;
    logic [ADDR_W:0] wr_ptr_reg;
    logic [WORD_W-1:0] wdata_reg;
    logic [CRC_W-1:0] crc_reg;
    logic erased_reg;
    logic mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [WORD_W-1:0] mem_wdata;
    logic [WORD_W-1:0] last_word;

    assign last_word = mem[DEPTH-1];

    always_comb
    begin
        mem_we = 1'b0;
        mem_addr = addr_reg[ADDR_W-1:0];
        mem_wdata = ERASED_WORD;
        if (state_reg == ST_ERASE && !addr_reg[ADDR_W])
        begin
            mem_we = 1'b1;
        end
        else if (state_reg == ST_WRITE && timer_reg == TMR_W'(WRITE_CYC - 1))
        begin
            mem_we = 1'b1;
            mem_addr = wr_ptr_reg[ADDR_W-1:0];
            mem_wdata = wdata_reg;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (mem_we)
        begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    // only erase, write, checksum and last-word read once entered
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            timer_reg <= '0;
            addr_reg <= '0;
            wr_ptr_reg <= '0;
            wdata_reg <= '0;
            crc_reg <= CRC_INIT;
            erased_reg <= 1'b0;
            tx_load_reg <= 1'b0;
            tx_word_reg <= '0;
            cmd_refused <= 1'b0;
        end
        else if (!prog_voltage_high)
        begin
            state_reg <= ST_IDLE;
            erased_reg <= 1'b0;
            tx_load_reg <= 1'b0;
            cmd_refused <= 1'b0;
        end
        else
        begin
            tx_load_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (cmd_valid)
                    begin
                        cmd_refused <= !(cmd.op == OP_ENTER &&
                            cmd.data == SETUP_KEY);
                        if (cmd.op == OP_ENTER && cmd.data == SETUP_KEY)
                        begin
                            state_reg <= ST_READY;
                        end
                    end
                end
                ST_READY:
                begin
                    if (cmd_valid)
                    begin
                        cmd_refused <= 1'b0;
                        if (cmd.op == OP_ERASE)
                        begin
                            state_reg <= ST_ERASE;
                            timer_reg <= TMR_W'(ERASE_CYC - 1);
                            addr_reg <= '0;
                            erased_reg <= 1'b0;
                        end
                        else if (cmd.op == OP_WRITE && erased_reg &&
                            !wr_ptr_reg[ADDR_W])
                        begin
                            state_reg <= ST_WRITE;
                            timer_reg <= TMR_W'(WRITE_CYC - 1);
                            wdata_reg <= cmd.data;
                        end
                        else if (cmd.op == OP_CRC)
                        begin
                            state_reg <= ST_CRC;
                            addr_reg <= '0;
                            crc_reg <= CRC_INIT;
                        end
                        else if (cmd.op == OP_READ_LAST)
                        begin
                            state_reg <= ST_SEND;
                            tx_word_reg <= last_word;
                            tx_load_reg <= 1'b1;
                        end
                        else
                        begin
                            cmd_refused <= 1'b1;
                        end
                    end
                end
                ST_ERASE:
                begin
                    if (!addr_reg[ADDR_W])
                    begin
                        addr_reg <= addr_reg + 1'b1;
                    end
                    timer_reg <= timer_reg - 1'b1;
                    if (timer_reg == '0 && addr_reg[ADDR_W])
                    begin
                        state_reg <= ST_READY;
                        erased_reg <= 1'b1;
                        wr_ptr_reg <= '0;
                    end
                end
                ST_WRITE:
                begin
                    timer_reg <= timer_reg - 1'b1;
                    if (timer_reg == '0)
                    begin
                        state_reg <= ST_READY;
                        wr_ptr_reg <= wr_ptr_reg + 1'b1;
                    end
                end
                ST_CRC:
                begin
                    crc_reg <= crc_step(crc_reg, mem[addr_reg[ADDR_W-1:0]]);
                    addr_reg <= addr_reg + 1'b1;
                    if (addr_reg == (ADDR_W+1)'(DEPTH - 1))
                    begin
                        state_reg <= ST_SEND;
                        tx_word_reg <= {{(WORD_W-CRC_W){1'b0}},
                            crc_step(crc_reg, mem[addr_reg[ADDR_W-1:0]])};
                        tx_load_reg <= 1'b1;
                    end
                end
                ST_SEND:
                begin
                    if (tx_done)
                    begin
                        state_reg <= ST_READY;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Pin configuration outputs
    // ****************************************************************
    // forced port setup
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_force <= '0;
            prog_mode <= 1'b0;
            serial_data_pin_out <= 1'b0;
            serial_data_pin_oe <= 1'b0;
        end
        else
        begin
            port_force.force_en <= prog_voltage_high;
            port_force.first_oe <= prog_voltage_high ? 8'hFF : 8'h00;
            port_force.first_out <= 8'h00;
            port_force.low_bits_oe <= 5'h00;
            port_force.six_oe <= prog_voltage_high;
            // Bit six reports busy so a programmer may poll it
            port_force.six_out <= prog_voltage_high &&
                state_reg != ST_READY && state_reg != ST_IDLE;
            prog_mode <= prog_voltage_high && state_reg != ST_IDLE;
            serial_data_pin_out <= sdo;
            serial_data_pin_oe <= sdo_oe;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_pins_input_high: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        prog_voltage_high |=> port_force.force_en && !serial_clock_pin_oe
        ##1 !serial_data_pin_oe || state_reg == ST_SEND)
        else $error("serial pins not inputs in program mode");
    chk_write_only_mode: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        mem_we |-> state_reg == ST_ERASE || state_reg == ST_WRITE)
        else $error("memory written outside erase or write");
    chk_port_forced: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        prog_voltage_high ##1 prog_voltage_high |-> port_force.first_oe ==
        8'hFF && port_force.first_out == 8'h00 &&
        port_force.low_bits_oe == 5'h00 && port_force.six_oe)
        else $error("port not forced while programming");
    chk_write_after_erase: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        state_reg == ST_WRITE && mem_we |-> erased_reg &&
        mem_addr == wr_ptr_reg[ADDR_W-1:0])
        else $error("word write before erase or out of sequence");
    chk_write_range: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        $rose(state_reg == ST_WRITE) |-> !wr_ptr_reg[ADDR_W])
        else $error("write beyond memory depth");
    chk_erase_timing: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        state_reg == ST_ERASE && timer_reg != '0 && prog_voltage_high
        |=> state_reg == ST_ERASE && timer_reg == $past(timer_reg) - 1'b1)
        else $error("erase left before its time");
    chk_send_source: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        tx_load_reg && $past(state_reg) == ST_CRC |->
        tx_word_reg[WORD_W-1:CRC_W] == '0 && tx_word_reg[CRC_W-1:0] ==
        crc_reg) else $error("sent word is not the checksum");
    chk_last_read: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        state_reg == ST_READY && cmd_valid && cmd.op == OP_READ_LAST &&
        prog_voltage_high |=> tx_load_reg && tx_word_reg == last_word)
        else $error("last word not loaded for read back");
    chk_leave_mode: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        !prog_voltage_high |=> state_reg == ST_IDLE && !port_force.force_en
        ##1 !prog_mode || prog_voltage_high)
        else $error("programming mode held with terminal low");
endmodule : fpm_prog_ctrl

// File: test/fpm_programmer.sv
// Programmer model on the serial clock and data pins.
// Assumes the device samples both pins on the core clock.
`timescale 1ns/10ps
module fpm_programmer
(
    input wire logic clk, // Core clock
    input wire logic dev_out, // Device data value
    input wire logic dev_oe, // Device data enable
    output logic sclk, // Serial clock
    output logic sdata // Data line level
);
    logic drv = 1'b0;
    assign sdata = dev_oe ? dev_out : drv;
    // Clock stands low outside frames
    initial sclk = 1'b0;
    task automatic pulse;
        repeat (2) @(negedge clk);
        sclk = 1'b1;
        repeat (2) @(negedge clk);
        sclk = 1'b0;
    endtask : pulse
    task automatic send_frame(input logic [25:0] f);
        for (int i = 25; i >= 0; i--)
        begin
            drv = f[i];
            pulse();
        end
        // Released line flips so a stale bit never reads as data
        drv = ~drv;
    endtask : send_frame
    task automatic read_word(output logic [21:0] w);
        int n;
        n = 0;
        while (dev_oe !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        for (int i = 21; i >= 0; i--)
        begin
            w[i] = sdata;
            pulse();
            repeat (3) @(negedge clk);
        end
    endtask : read_word
endmodule : fpm_programmer

// File: test/tb_flash_program_mode_control.sv
// Bench comparing the controller with a queue model of the array.
// Assumes the programmer model drives the serial pins.
`timescale 1ns/10ps
module tb_flash_program_mode_control;
    import fpm_pkg::*;
    localparam int DEP = 16;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic prog_voltage_high = 1'b0;
    logic sclk, sdin, sdout, sdoe, prog_mode, cmd_refused;
    fpm_pins_type port_force;
    fpm_pins_type forced = '{1'b1, 8'hFF, 8'h00, 5'h00, 1'b1, 1'b0};
    int fail_count = 0;
    int num_checks = 0;
    int seed = 32'h28f9_c211;
    logic [21:0] mem [$];
    logic [21:0] got;
    initial forever #5 core_clk = ~core_clk;
    fpm_prog_ctrl #(.DEPTH(DEP), .ERASE_CYC(40), .WRITE_CYC(10)) dut (
        .core_clk(core_clk), .rstn(rstn),
        .prog_voltage_high(prog_voltage_high),
        .serial_clock_pin_in(sclk), .serial_clock_pin_oe(1'b0),
        .serial_data_pin_in(sdin), .serial_data_pin_out(sdout),
        .serial_data_pin_oe(sdoe), .port_force(port_force),
        .prog_mode(prog_mode), .cmd_refused(cmd_refused));
    fpm_programmer prog (.clk(core_clk), .dev_out(sdout), .dev_oe(sdoe),
        .sclk(sclk), .sdata(sdin));
    task automatic bad(input string n, input logic [23:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : bad
    task automatic chk_word(input string n, input logic [21:0] e, g);
        bad(n, {2'b00, e}, {2'b00, g});
    endtask : chk_word
    task automatic chk_pins(input string n, input fpm_pins_type e);
        bad(n, e, port_force);
    endtask : chk_pins
    task automatic chk_stat(input string n, input logic [1:0] e);
        bad(n, {22'h0, e}, {22'h0, prog_mode, cmd_refused});
    endtask : chk_stat
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    task automatic cmd(input logic [3:0] op, input logic [21:0] d);
        int n;
        n = 0;
        prog.send_frame({op, d});
        repeat (4) @(negedge core_clk);
        while (port_force.six_out !== 1'b0 && n < 200)
        begin
            @(negedge core_clk);
            n++;
        end
    endtask : cmd
    task automatic read_crc(input string n);
        logic [15:0] c;
        c = CRC_INIT;
        foreach (mem[i])
            for (int b = 21; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ mem[i][b]) ? CRC_POLY : 16'h0);
        prog.send_frame({OP_CRC, 22'h0});
        prog.read_word(got);
        chk_word(n, {6'h00, c}, got);
        repeat (4) @(negedge core_clk);
    endtask : read_crc
    initial
    begin
        repeat (10) @(negedge core_clk);
        rstn = 1'b1;
        repeat (4) @(negedge core_clk);
        chk_pins("pins_reset", '0);
        prog_voltage_high = 1'b1;
        repeat (3) @(negedge core_clk);
        chk_pins("pins_forced", forced);
        chk_word("data_oe", 22'h0, {21'h0, sdoe});
        cmd(OP_ENTER, ~SETUP_KEY);
        chk_stat("bad_key", 2'b01);
        cmd(OP_ENTER, SETUP_KEY);
        chk_stat("enter", 2'b10);
        cmd(OP_WRITE, 22'h1);
        chk_stat("early_write", 2'b11);
        prog.send_frame({OP_ERASE, 22'h0});
        repeat (4) @(negedge core_clk);
        bad("busy", 24'h1, {23'h0, port_force.six_out});
        wait (port_force.six_out == 1'b0);
        repeat (2) @(negedge core_clk);
        chk_stat("erase", 2'b10);
        for (int i = 0; i < DEP; i++)
            mem.push_back(ERASED_WORD);
        read_crc("crc_erased");
        for (int i = 0; i < DEP; i++)
        begin
            mem[i] = 22'($random(seed));
            cmd(OP_WRITE, mem[i]);
            chk_stat("write", 2'b10);
        end
        cmd(OP_WRITE, 22'h0);
        chk_stat("over_depth", 2'b11);
        read_crc("crc_written");
        prog.send_frame({OP_READ_LAST, 22'h0});
        prog.read_word(got);
        chk_word("last_word", mem[DEP-1], got);
        repeat (4) @(negedge core_clk);
        cmd(4'hF, 22'h0);
        chk_stat("bad_op", 2'b11);
        prog_voltage_high = 1'b0;
        repeat (3) @(negedge core_clk);
        chk_pins("pins_released", '0);
        chk_stat("left", 2'b00);
        report_and_stop();
    end
    initial
    begin
        repeat (40000) @(posedge core_clk);
        fail_count++;
        report_and_stop();
    end
endmodule : tb_flash_program_mode_control
